// File: dmsc_pkg.sv
`default_nettype none
package dmsc_pkg;
    localparam logic [6:0] SPI_CHIP_ADDR  = 7'h10;
    localparam logic [3:0] I2C_ADDR_HI    = 4'h2;
    localparam int         PTR_STEP_BIT   = 7;
    localparam int         IDX_W          = 7;
    localparam logic [7:0] PTR_RESET      = 8'h00;
    localparam int         REG_COUNT      = 128;
    localparam logic [1:0] ARM_DONE       = 2'h3;
    localparam int         CLK_NS         = 50;
    localparam int         SPI_PERIOD_NS  = 400;
    localparam int         I2C_PERIOD_NS  = 10000;
    localparam logic [5:0] SPI_QTR_CYC    =
        6'(SPI_PERIOD_NS / (4 * CLK_NS));
    localparam logic [5:0] I2C_QTR_CYC    =
        6'(I2C_PERIOD_NS / (4 * CLK_NS));
    localparam logic [7:0] OFS_CMD        = 8'h00;
    localparam logic [7:0] OFS_PTR        = 8'h04;
    localparam logic [7:0] OFS_WDATA      = 8'h08;
    localparam logic [7:0] OFS_RDATA      = 8'h0c;
    localparam logic [7:0] OFS_STAT       = 8'h10;
    localparam int         CMD_GO         = 0;
    localparam int         CMD_RD         = 1;
    localparam int         CMD_I2C        = 2;
    localparam int         CMD_PONLY      = 3;
    localparam int         CMD_ALO        = 4;
    localparam logic [6:0] RSV_A          = 7'h00;
    localparam logic [6:0] RSV_B          = 7'h06;
    localparam logic [6:0] RSV_C_LO       = 7'h0f;
    localparam logic [6:0] RSV_C_HI       = 7'h11;
    localparam logic [6:0] RSV_D_LO       = 7'h1d;
    localparam logic [6:0] RSV_D_HI       = 7'h1f;
endpackage
`default_nettype wire

// File: dmsc_if.sv
`timescale 1ns/1ns
`default_nettype none
interface dmsc_if;
    logic serial_control_clock;
    logic addr0_or_select_pin;
    logic control_serial_input;
    logic host_data_oe_n;
    logic dev_data_oe_n;
    logic control_serial_output;
    logic control_serial_output_oe_n;
    logic data_line;
    logic control_serial_output_line;
    // Pulled up wires; drivers only pull low on the shared data line
    assign data_line = (host_data_oe_n | control_serial_input)
                       & dev_data_oe_n;
    assign control_serial_output_line = control_serial_output_oe_n | control_serial_output;
    modport dev (
        input  serial_control_clock,
        input  addr0_or_select_pin,
        input  data_line,
        output dev_data_oe_n,
        output control_serial_output,
        output control_serial_output_oe_n
    );
    modport host (
        output serial_control_clock,
        output addr0_or_select_pin,
        output control_serial_input,
        output host_data_oe_n,
        input  data_line,
        input  control_serial_output_line
    );
endinterface
`default_nettype wire

// File: dmsc_device.sv
`timescale 1ns/1ns
`default_nettype none
// How it works
// - Select fall after reset picks SPI
// - SPI samples rising, launches on falling edge
// - Host sends SPI chip address 0010000 first
// - Eighth bit: low write, high read
// - SPI write: pointer byte, then data byte
// - SPI output stays released during writes
// - Auto-step set: pointer advances per byte
// - Host sets pointer by short write first
// - SPI read drives MSB on next falling
// - I2C address 0010 plus three strap levels
// - I2C write: pointer byte, then data bytes
// - I2C read sends selected registers in turn
// - Device acknowledges a matching address and each byte written; the host releases the data line after a read byte
// - I2C read: pointer write, stop, read
// - Pointer: step bit high, index low
// - Host keeps pins static when idle
// - Pointer index resets to zero
// - Host never writes reserved locations
module dmsc_device
    import dmsc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        resetn,
    dmsc_if.dev              link,
    input  wire logic        address_strap_bit1,
    input  wire logic        address_strap_bit2,
    output logic             spi_mode,
    output logic [7:0]       pointer_value,
    output logic             reg_wr_strobe,
    output logic [IDX_W-1:0] reg_wr_index,
    output logic [7:0]       reg_wr_data
);

    typedef enum logic [2:0] {
        PH_IDLE,
        PH_ADDR,
        PH_PTR,
        PH_DATA,
        PH_READ,
        PH_IGNORE
    } dmsc_phase_type;

    typedef struct packed {
        logic [2:0]                scl_s;
        logic [2:0]                sel_s;
        logic [2:0]                sda_s;
        logic [1:0]                a1_s;
        logic [1:0]                a2_s;
        logic [1:0]                arm;
        logic                      spi;
        dmsc_phase_type            ph;
        logic [3:0]                cnt;
        logic [7:0]                shr;
        logic [7:0]                tx;
        logic [3:0]                rcnt;
        logic                      ack_ok;
        logic [7:0]                ptr;
        logic [REG_COUNT-1:0][7:0] regs;
        logic                      sda_oe_n;
        logic                      so;
        logic                      so_oe_n;
        logic                      wr_stb;
        logic [IDX_W-1:0]          wr_idx;
        logic [7:0]                wr_dat;
    } dmsc_dev_state_type;

    dmsc_dev_state_type r;
    dmsc_dev_state_type n;
    logic               rise;
    logic               fall;
    logic               scl_hi;
    logic               sda_fall;
    logic               sda_rise;
    logic               sel_fall;
    logic [7:0]         b;
    logic [7:0]         np;
    logic               done;
    logic               ok;

    // Only second and third sync stages feed edge logic
    assign rise     = r.scl_s[1] & ~r.scl_s[2];
    assign fall     = ~r.scl_s[1] & r.scl_s[2];
    assign scl_hi   = r.scl_s[1] & r.scl_s[2];
    assign sda_fall = ~r.sda_s[1] & r.sda_s[2];
    assign sda_rise = r.sda_s[1] & ~r.sda_s[2];
    assign sel_fall = ~r.sel_s[1] & r.sel_s[2];

    always_comb begin
        n = r;
        b = {r.shr[6:0], r.sda_s[1]};
        np = r.ptr;
        if (r.ptr[PTR_STEP_BIT]) begin
            np = {1'b1, r.ptr[IDX_W-1:0] + 7'h01};
        end
        done = 1'b0;
        ok = 1'b0;
        n.wr_stb = 1'b0;
        n.scl_s = {r.scl_s[1:0], link.serial_control_clock};
        n.sel_s = {r.sel_s[1:0], link.addr0_or_select_pin};
        n.sda_s = {r.sda_s[1:0], link.data_line};
        n.a1_s = {r.a1_s[0], address_strap_bit1};
        n.a2_s = {r.a2_s[0], address_strap_bit2};

        if (r.spi) begin
            if (r.sel_s[1]) begin
                n.ph = PH_ADDR;
                n.cnt = 4'h0;
                n.rcnt = 4'h0;
                n.so_oe_n = 1'b1;
            end else if (rise && r.ph != PH_READ
                         && r.ph != PH_IGNORE) begin
                n.shr = b;
                done = (r.cnt == 4'h7);
                n.cnt = done ? 4'h0 : r.cnt + 4'h1;
            end else if (fall && r.ph == PH_READ) begin
                n.so = r.tx[7];
                n.so_oe_n = 1'b0;
                n.tx = {r.tx[6:0], 1'b0};
                n.rcnt = r.rcnt + 4'h1;
                if (r.rcnt == 4'h7) begin
                    n.rcnt = 4'h0;
                    n.ptr = np;
                    n.tx = r.regs[np[IDX_W-1:0]];
                end
            end
        end else begin
            if (scl_hi && sda_fall) begin
                n.ph = PH_ADDR;
                n.cnt = 4'h0;
                n.rcnt = 4'h0;
                n.ack_ok = 1'b0;
                n.sda_oe_n = 1'b1;
            end else if (scl_hi && sda_rise) begin
                n.ph = PH_IDLE;
                n.ack_ok = 1'b0;
                n.sda_oe_n = 1'b1;
            end else if (rise) begin
                if (r.cnt == 4'h8) begin
                    n.cnt = 4'h0;
                end
                if (r.ph == PH_READ) begin
                    if (r.rcnt == 4'h8) begin
                        // Rise on a sent byte's eighth bit: reload next byte, a high line ends the read
                        n.rcnt = 4'h0;
                        n.ptr = np;
                        n.tx = r.regs[np[IDX_W-1:0]];
                        if (r.sda_s[1]) begin
                            n.ph = PH_IGNORE;
                        end
                    end
                end else if (r.ph != PH_IDLE && r.ph != PH_IGNORE
                             && r.cnt != 4'h8) begin
                    n.shr = b;
                    n.cnt = r.cnt + 4'h1;
                    done = (r.cnt == 4'h7);
                end
            end else if (fall) begin
                if (r.ack_ok) begin
                    n.sda_oe_n = 1'b0;
                    n.ack_ok = 1'b0;
                end else if (r.ph == PH_READ && r.rcnt != 4'h8) begin
                    // Open drain: a one is sent by releasing
                    n.sda_oe_n = r.tx[7];
                    n.tx = {r.tx[6:0], 1'b0};
                    n.rcnt = r.rcnt + 4'h1;
                end else begin
                    n.sda_oe_n = 1'b1;
                end
            end
        end

        if (done) begin
            case (r.ph)
                PH_ADDR: begin
                    if (r.spi) begin
                        ok = (b[7:1] == SPI_CHIP_ADDR);
                    end else begin
                        ok = (b[7:1] == {I2C_ADDR_HI, r.a2_s[1],
                                         r.a1_s[1], r.sel_s[1]});
                    end
                    n.ack_ok = ok & ~r.spi;
                    n.ph = PH_IGNORE;
                    if (ok && b[0]) begin
                        n.ph = PH_READ;
                        n.rcnt = 4'h0;
                        n.tx = r.regs[r.ptr[IDX_W-1:0]];
                    end else if (ok) begin
                        n.ph = PH_PTR;
                    end
                end
                PH_PTR: begin
                    n.ptr = b;
                    n.ph = PH_DATA;
                    n.ack_ok = ~r.spi;
                end
                PH_DATA: begin
                    n.regs[r.ptr[IDX_W-1:0]] = b;
                    n.wr_stb = 1'b1;
                    n.wr_idx = r.ptr[IDX_W-1:0];
                    n.wr_dat = b;
                    n.ptr = np;
                    n.ack_ok = ~r.spi;
                end
                default: begin
                end
            endcase
        end

        // Pin level settles through sync before a fall may count
        if (r.arm != ARM_DONE) begin
            n.arm = r.arm + 2'h1;
        end else if (!r.spi && sel_fall) begin
            n.spi = 1'b1;
            n.ph = PH_ADDR;
            n.cnt = 4'h0;
            n.ack_ok = 1'b0;
            n.sda_oe_n = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            r <= '0;
            r.scl_s <= 3'h7;
            r.sel_s <= 3'h7;
            r.sda_s <= 3'h7;
            r.ptr <= PTR_RESET;
            r.sda_oe_n <= 1'b1;
            r.so_oe_n <= 1'b1;
        end else begin
            r <= n;
        end
    end

    assign link.dev_data_oe_n = r.sda_oe_n;
    assign link.control_serial_output = r.so;
    assign link.control_serial_output_oe_n = r.so_oe_n;
    assign spi_mode = r.spi;
    assign pointer_value = r.ptr;
    assign reg_wr_strobe = r.wr_stb;
    assign reg_wr_index = r.wr_idx;
    assign reg_wr_data = r.wr_dat;

endmodule
`default_nettype wire

// File: dmsc_host.sv
`timescale 1ns/1ns
`default_nettype none
module dmsc_host
    import dmsc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    dmsc_if.host             link
);

    typedef enum logic [2:0] {
        H_IDLE,
        H_BEGIN,
        H_BITS,
        H_END,
        H_GAP
    } dmsc_hst_type;

    typedef struct packed {
        logic         rd;
        logic         i2c;
        logic         ponly;
        logic [2:0]   alo;
        logic [7:0]   ptr;
        logic [7:0]   wdat;
        logic [7:0]   rdat;
        logic         busy;
        logic         nack;
        logic         refused;
        dmsc_hst_type st;
        logic [1:0]   q;
        logic [5:0]   div;
        logic [3:0]   bitn;
        logic [1:0]   byten;
        logic         frame;
        logic [7:0]   sh;
        logic [1:0]   cdo_s;
        logic [1:0]   sda_s;
        logic         scl;
        logic         sel;
        logic         dout;
        logic         doe_n;
        logic         pready;
        logic         pslverr;
        logic [31:0]  prdata;
    } dmsc_host_state_type;

    dmsc_host_state_type r;
    dmsc_host_state_type n;
    logic               tick;
    logic               rx;
    logic               last;
    logic [1:0]         nbytes;
    logic [6:0]         chip;
    logic [7:0]         nxt;
    logic               rsv;

    always_comb begin
        n = r;
        n.cdo_s = {r.cdo_s[0], link.control_serial_output_line};
        n.sda_s = {r.sda_s[0], link.data_line};
        tick = r.busy && (r.div == (r.i2c ? I2C_QTR_CYC : SPI_QTR_CYC)
                          - 6'h01);
        n.div = (tick || !r.busy) ? 6'h00 : r.div + 6'h01;
        chip = r.i2c ? {I2C_ADDR_HI, r.alo} : SPI_CHIP_ADDR;
        rx = r.frame && r.byten == 2'h1;
        nbytes = (r.frame || r.rd || r.ponly) ? 2'h2 : 2'h3;
        last = r.bitn == (r.i2c ? 4'h8 : 4'h7);
        nxt = (r.byten == 2'h0) ? (r.frame ? 8'h00 : r.ptr) : r.wdat;
        rsv = r.ptr[6:0] == RSV_A || r.ptr[6:0] == RSV_B
              || (r.ptr[6:0] >= RSV_C_LO && r.ptr[6:0] <= RSV_C_HI)
              || (r.ptr[6:0] >= RSV_D_LO && r.ptr[6:0] <= RSV_D_HI);

        // One wait state keeps the answer on flip-flops
        n.pready = psel && penable && !r.pready;
        if (psel && penable && !r.pready) begin
            n.pslverr = 1'b0;
            n.prdata = 32'h0;
            if (paddr == OFS_CMD) begin
                n.prdata = {25'h0, r.alo, r.ponly, r.i2c, r.rd, r.busy};
            end else if (paddr == OFS_PTR) begin
                n.prdata = {24'h0, r.ptr};
            end else if (paddr == OFS_WDATA) begin
                n.prdata = {24'h0, r.wdat};
            end else if (paddr == OFS_RDATA) begin
                n.prdata = {24'h0, r.rdat};
            end else if (paddr == OFS_STAT) begin
                n.prdata = {29'h0, r.refused, r.nack, r.busy};
            end else begin
                n.pslverr = 1'b1;
            end
        end
        if (psel && penable && r.pready && pwrite && !r.busy) begin
            if (paddr == OFS_CMD) begin
                n.rd = pwdata[CMD_RD];
                n.i2c = pwdata[CMD_I2C];
                n.ponly = pwdata[CMD_PONLY];
                n.alo = pwdata[CMD_ALO +: 3];
                n.refused = pwdata[CMD_GO] && !pwdata[CMD_RD]
                            && !pwdata[CMD_PONLY] && rsv;
                if (pwdata[CMD_GO] && !n.refused) begin
                    n.busy = 1'b1;
                    n.nack = 1'b0;
                    n.st = H_BEGIN;
                    n.q = 2'h0;
                    n.frame = 1'b0;
                    n.scl = 1'b1;
                end
            end else if (paddr == OFS_PTR) begin
                n.ptr = pwdata[7:0];
            end else if (paddr == OFS_WDATA) begin
                n.wdat = pwdata[7:0];
            end
        end

        if (tick) begin
            n.q = r.q + 2'h1;
            case (r.st)
                H_BEGIN: begin
                    if (r.q == 2'h0) begin
                        n.doe_n = r.i2c;
                        n.dout = 1'b0;
                        n.sel = r.i2c;
                    end else if (r.q == 2'h2) begin
                        n.doe_n = 1'b0;
                    end else if (r.q == 2'h3) begin
                        n.st = H_BITS;
                        n.bitn = 4'h0;
                        n.byten = 2'h0;
                        n.sh = {chip, r.frame};
                    end
                end
                H_BITS: begin
                    if (r.q == 2'h0) begin
                        n.scl = 1'b0;
                        n.dout = r.i2c ? 1'b0 : (r.sh[7] && !rx);
                        n.doe_n = r.i2c ? (r.sh[7] || rx
                                           || r.bitn == 4'h8) : 1'b0;
                    end else if (r.q == 2'h2) begin
                        n.scl = 1'b1;
                    end else if (r.q == 2'h3) begin
                        n.sh = {r.sh[6:0], 1'b0};
                        n.bitn = r.bitn + 4'h1;
                        if (rx && r.bitn != 4'h8) begin
                            n.rdat = {r.rdat[6:0],
                                      r.i2c ? r.sda_s[1] : r.cdo_s[1]};
                        end
                        if (last) begin
                            n.bitn = 4'h0;
                            n.byten = r.byten + 2'h1;
                            n.sh = nxt;
                            n.nack = r.i2c && !rx && r.sda_s[1];
                            if (n.nack || r.byten == nbytes - 2'h1) begin
                                n.st = H_END;
                            end
                        end
                    end
                end
                H_END: begin
                    if (r.q == 2'h0) begin
                        n.scl = !r.i2c;
                        n.doe_n = 1'b0;
                    end else if (r.q == 2'h1) begin
                        n.scl = 1'b1;
                    end else if (r.q == 2'h2) begin
                        n.doe_n = r.i2c;
                        n.sel = 1'b1;
                        // Park data as select rises, never mid-frame
                        n.dout = 1'b0;
                    end else if (r.q == 2'h3) begin
                        n.st = H_GAP;
                    end
                end
                H_GAP: begin
                    if (r.q == 2'h3) begin
                        if (!r.frame && r.rd && !r.nack) begin
                            n.frame = 1'b1;
                            n.st = H_BEGIN;
                        end else begin
                            n.st = H_IDLE;
                            n.busy = 1'b0;
                        end
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            r <= '0;
            r.cdo_s <= 2'h3;
            r.sda_s <= 2'h3;
            r.scl <= 1'b1;
            r.sel <= 1'b1;
            r.doe_n <= 1'b1;
        end else begin
            r <= n;
        end
    end

    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;
    assign link.serial_control_clock = r.scl;
    assign link.addr0_or_select_pin = r.sel;
    assign link.control_serial_input = r.dout;
    assign link.host_data_oe_n = r.doe_n;

endmodule
`default_nettype wire

// File: dmsc_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module dmsc_asserts (
    input wire logic clk,
    input wire logic resetn,
    input wire logic serial_control_clock,
    input wire logic addr0_or_select_pin,
    input wire logic control_serial_input,
    input wire logic dev_data_oe_n,
    input wire logic control_serial_output,
    input wire logic control_serial_output_oe_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence s_sel_rel;
        $rose(addr0_or_select_pin);
    endsequence
    sequence s_ack_on;
        $fell(dev_data_oe_n);
    endsequence
    sequence s_out_move;
        $fell(control_serial_output_oe_n) ||
        (!control_serial_output_oe_n && $changed(control_serial_output));
    endsequence
    AST_RESET_IDLE: assert property ($rose(resetn) |-> dev_data_oe_n
        && control_serial_output_oe_n && addr0_or_select_pin)
        else $error("lines not idle after reset");
    AST_OUT_RELEASE: assert property (s_sel_rel |-> ##[0:4]
        control_serial_output_oe_n) else $error("output not released");
    AST_OUT_UNSEL: assert property (addr0_or_select_pin[*5] |->
        control_serial_output_oe_n) else $error("output driven unselected");
    // Sync delay is 3 to 4 clocks, low phase lasts 4
    AST_OUT_FALL: assert property (s_out_move |->
        !$past(serial_control_clock, 3)) else $error("output not on fall");
    AST_HOST_DATA: assert property (!addr0_or_select_pin &&
        $changed(control_serial_input) |-> !serial_control_clock)
        else $error("host data moved with clock high");
    AST_SPI_NO_SDA: assert property (!addr0_or_select_pin |->
        dev_data_oe_n) else $error("data line pulled in frame");
    AST_ACK_EDGE: assert property (($fell(dev_data_oe_n) ||
        $rose(dev_data_oe_n)) |-> !serial_control_clock)
        else $error("data line moved with clock high");
    AST_ACK_HOLD: assert property (s_ack_on |=> !dev_data_oe_n[*8])
        else $error("acknowledge too short");
    AST_ONE_DRV: assert property (!control_serial_output_oe_n |->
        dev_data_oe_n) else $error("both outputs driven");
endmodule
`default_nettype wire

// File: testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench
    import dmsc_pkg::*;
;
    logic        clk;
    logic        resetn;
    logic [7:0]  paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        strap1;
    logic        strap2;
    logic        spi_mode;
    logic [7:0]  pointer_value;
    logic        reg_wr_strobe;
    logic [6:0]  reg_wr_index;
    logic [7:0]  reg_wr_data;
    logic [31:0] rd;
    logic        er;
    int          n_errors;
    int          total_checks;
    int          n_wr;
    dmsc_if link_if ();
    dmsc_host dmsc_host_i (.clk(clk), .resetn(resetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .link(link_if));
    dmsc_device dmsc_device_i (.clk(clk), .resetn(resetn), .link(link_if),
        .address_strap_bit1(strap1), .address_strap_bit2(strap2),
        .spi_mode(spi_mode), .pointer_value(pointer_value),
        .reg_wr_strobe(reg_wr_strobe), .reg_wr_index(reg_wr_index),
        .reg_wr_data(reg_wr_data));
    dmsc_asserts dmsc_asserts_i (.clk(clk), .resetn(resetn),
        .serial_control_clock(link_if.serial_control_clock),
        .addr0_or_select_pin(link_if.addr0_or_select_pin),
        .control_serial_input(link_if.control_serial_input),
        .dev_data_oe_n(link_if.dev_data_oe_n),
        .control_serial_output(link_if.control_serial_output),
        .control_serial_output_oe_n(link_if.control_serial_output_oe_n));
    always #25 clk = ~clk;
    always @(posedge clk) begin
        if (reg_wr_strobe === 1'b1) begin
            n_wr <= n_wr + 1;
        end
    end
    task end_sim();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            chk("pready", 1'b1, pready);
            end_sim();
        end
    endtask
    // Busy polled, since frame length depends on mode
    task run(input logic [7:0] c);
        int n;
        apb(1'b1, OFS_CMD, {24'h0, c});
        n = 0;
        do begin
            apb(1'b0, OFS_STAT, 32'h0);
            n++;
        end while (rd[0] !== 1'b0 && n < 4000);
        if (rd[0] !== 1'b0) begin
            chk("busy", 1'b0, rd[0]);
            end_sim();
        end
    endtask
    function automatic logic [7:0] cm(input logic r, i, p,
                                      input logic [2:0] al);
        cm = {1'b0, al, p, i, r, 1'b1};
    endfunction
    task t_reset();
        chk("pointer", 8'h00, pointer_value);
        chk("step bit", 1'b0, pointer_value[PTR_STEP_BIT]);
        chk("spi mode", 1'b0, spi_mode);
        apb(1'b0, 8'h14, 32'h0);
        chk("unmapped", 1'b1, er);
        $display("reset test done");
    endtask
    task t_i2c_wr();
        int w;
        w = n_wr;
        apb(1'b1, OFS_PTR, 32'h85);
        apb(1'b1, OFS_WDATA, 32'ha5);
        run(cm(1'b0, 1'b1, 1'b0, 3'h3));
        chk("nack", 1'b0, rd[1]);
        chk("stores", w + 1, n_wr);
        chk("index", 7'h05, reg_wr_index);
        chk("data", 8'ha5, reg_wr_data);
        chk("pointer", 8'h86, pointer_value);
        $display("i2c write test done");
    endtask
    task t_i2c_bad();
        int w;
        w = n_wr;
        run(cm(1'b0, 1'b1, 1'b0, 3'h7));
        chk("nack", 1'b1, rd[1]);
        chk("stores", w, n_wr);
        chk("pointer", 8'h86, pointer_value);
        apb(1'b1, OFS_PTR, 32'h06);
        run(cm(1'b0, 1'b1, 1'b0, 3'h3));
        chk("refused", 1'b1, rd[2]);
        chk("stores", w, n_wr);
        $display("i2c refusal test done");
    endtask
    task t_i2c_rd();
        apb(1'b1, OFS_PTR, 32'h05);
        run(cm(1'b0, 1'b1, 1'b1, 3'h3));
        chk("pointer", 8'h05, pointer_value);
        run(cm(1'b1, 1'b1, 1'b0, 3'h3));
        chk("pointer", 8'h05, pointer_value);
        apb(1'b0, OFS_RDATA, 32'h0);
        chk("read data", 8'ha5, rd);
        $display("i2c read test done");
    endtask
    task t_spi();
        int w;
        w = n_wr;
        apb(1'b1, OFS_PTR, 32'h87);
        apb(1'b1, OFS_WDATA, 32'h3c);
        run(cm(1'b0, 1'b0, 1'b0, 3'h0));
        chk("spi mode", 1'b1, spi_mode);
        chk("stores", w + 1, n_wr);
        chk("index", 7'h07, reg_wr_index);
        chk("data", 8'h3c, reg_wr_data);
        chk("pointer", 8'h88, pointer_value);
        run(cm(1'b0, 1'b0, 1'b1, 3'h0));
        chk("pointer", 8'h87, pointer_value);
        run(cm(1'b1, 1'b0, 1'b0, 3'h0));
        apb(1'b0, OFS_RDATA, 32'h0);
        chk("read data", 8'h3c, rd);
        chk("pointer", 8'h88, pointer_value);
        $display("spi test done");
    endtask
    initial begin
        clk = 1'b0;
        resetn = 1'b0;
        paddr = 8'h00;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        pwdata = 32'h0;
        strap1 = 1'b1;
        strap2 = 1'b0;
        n_errors = 0;
        total_checks = 0;
        n_wr = 0;
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        repeat (4) @(posedge clk);
        t_reset();
        t_i2c_wr();
        t_i2c_bad();
        t_i2c_rd();
        // Selecting SPI is sticky, so it goes last
        t_spi();
        end_sim();
    end
endmodule
`default_nettype wire
